//--- common/genlock_lock_control_regs.vh
// Register map, field positions, reset values and timing constants of the genlock lock control
// Function
// - Default tolerance code keeps lock within about 0.2 percent reference line drift.
// - Drift tolerance register at 1Eh, host writable, resets to Bh.
// - Tolerance code k allows drift of two to the power k minus 20.
// - 59.94Hz and 60Hz reference standards stay distinct whatever the tolerance.
// - Lock attempted only while reference-lost and lock request input are low.
// - Valid recognised reference consults the format table for permission to lock.
// - Permitted lock: lock format, apply timing offsets, then drop lock-lost low.
// - Lock impossible: hold lock-lost high and run free from the crystal.
// - Status register shows separate line, picture and field lock indications.
// - Control bits let the host ignore bad line, picture or field timing.
// - Mask at 11h-13h disables any of 36 standards; locking to one fails.
// - Disabling the applied standard while already locked keeps the lock.
// - Reset mask disables all high-definition reference formats.
// - Crash lock by default; crash behaviour set by a field of 24h.
// - Bit 1 of 16h high selects drift lock instead of crash lock.
// - Reference removed and reapplied while locked re-acquires by drift lock.
// - Video loop defaults to 10Hz for matched formats; cross-lock may differ.
// - Video loop capacitive coefficient from 26h, resistive coefficient from 27h.
// - Audio loop capacitive coefficient from 39h, resistive coefficient from 3Ah.
// - Triple rate sound enable is bit 5 of 31h and resets low.
`ifndef GENLOCK_LOCK_CONTROL_REGS_VH
`define GENLOCK_LOCK_CONTROL_REGS_VH
// Register indices; byte address is four times the index
`define IDX_MASK_LO 8'h11
`define IDX_MASK_MID 8'h12
`define IDX_MASK_HI 8'h13
`define IDX_GEN_CTRL 8'h16
`define IDX_GEN_STAT 8'h17
`define IDX_TOLERANCE 8'h1e
`define IDX_RUN_CTRL 8'h24
`define IDX_VCAP 8'h26
`define IDX_VRES 8'h27
`define IDX_AUDIO_CTRL 8'h31
`define IDX_ACAP 8'h39
`define IDX_ARES 8'h3a
// Field positions
`define CTRL_DRIFT_BIT 1
`define CTRL_IGN_H_BIT 2
`define CTRL_IGN_V_BIT 3
`define CTRL_IGN_F_BIT 4
`define AUD_TRIPLE_BIT 5
`define CRASH_LSB 4
`define CRASH_MSB 7
// Reset values
`define TOL_RESET 4'hb
`define MASK_RESET 48'h0000_0003_f000
`define CTRL_RESET 16'h0000
`define RUN_RESET 16'h0013
`define VCAP_RESET 16'h0010
`define VRES_RESET 16'h0025
`define ACAP_RESET 16'h0010
`define ARES_RESET 16'h0025
`define AUD_RESET 16'h0000
// Tolerance shift base, format count and drift lock line count
`define TOL_EXP_BASE 5'd20
`define NUM_STANDARDS 6'd36
`define DRIFT_LINES 5'd16
// Reference presence timeouts
`define CLK_HZ 20000000
`define FRAME_GAP_US 50000
`endif

//--- design/genlock_lock_control.v
// Genlock decision and PLL lock control with a classic Wishbone register slave
`include "genlock_lock_control_regs.vh"
module genlock_lock_control #(
   parameter PW = 16,
   parameter FRAME_GAP_CYC = `FRAME_GAP_US * (`CLK_HZ / 1000000)
)(
   input wire SYS_CLK,
   input wire RSTN,
   input wire CE,
   // Wishbone classic slave
   input wire WB_CYC_I,
   input wire WB_STB_I,
   input wire WB_WE_I,
   input wire [9:0] WB_ADR_I,
   input wire [3:0] WB_SEL_I,
   input wire [31:0] WB_DAT_I,
   output reg [31:0] WB_DAT_O,
   output reg WB_ACK_O,
   // Reference pins
   input wire LINE_REFERENCE_IN,
   input wire PICTURE_REFERENCE_IN,
   input wire FIELD_REFERENCE_IN,
   input wire LOCK_REQUEST_LOW_N,
   // Format detector and cross-reference table, same clock
   input wire FORMAT_VALID,
   input wire [5:0] REF_FORMAT,
   input wire TABLE_PERMIT,
   // Lock outputs
   output reg REF_LOST,
   output reg LOCK_LOST,
   output reg DRIFT_MODE,
   output reg OFFSET_APPLY,
   output reg [15:0] VIDEO_CAP,
   output reg [15:0] VIDEO_RES,
   output reg [15:0] SOUND_CAP,
   output reg [15:0] SOUND_RES,
   output reg TRIPLE_RATE_SOUND_ENABLE
);

   // ----------------------------------------------------------------
   // States
   // ----------------------------------------------------------------
   localparam ST_FREE = 2'b00;
   localparam ST_CHECK = 2'b01;
   localparam ST_LOCKING = 2'b10;
   localparam ST_LOCKED = 2'b11;

   reg [1:0] state_reg;
   reg [1:0] state_next;

   // Register file
   reg [47:0] mask_reg;
   reg [15:0] ctrl_reg;
   reg [3:0] tol_reg;
   reg [15:0] run_reg;
   reg [15:0] vcap_reg;
   reg [15:0] vres_reg;
   reg [15:0] acap_reg;
   reg [15:0] ares_reg;
   reg [15:0] aud_reg;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   reg [3:0] pin_meta_reg;
   reg [3:0] pin_sync_reg;
   reg [2:0] pin_last_reg;

   // Two flops per pin; the second stage and, on the reference pins, a third flop behind it feed the edge detect
   always @(posedge SYS_CLK)
   begin
      if (!RSTN)
      begin
         pin_meta_reg <= 4'h8;
         pin_sync_reg <= 4'h8;
         pin_last_reg <= 3'h0;
      end
      else if (CE)
      begin
         pin_meta_reg <= {LOCK_REQUEST_LOW_N, FIELD_REFERENCE_IN, PICTURE_REFERENCE_IN, LINE_REFERENCE_IN};
         pin_sync_reg <= pin_meta_reg;
         pin_last_reg <= pin_sync_reg[2:0];
      end
   end

   wire [2:0] pin_rise = pin_sync_reg[2:0] & ~pin_last_reg;
   wire h_edge = pin_rise[0];
   wire v_edge = pin_rise[1];
   wire f_edge = pin_rise[2];
   wire lock_request_low = ~pin_sync_reg[3];

   // ----------------------------------------------------------------
   // Line period measurement and drift check
   // ----------------------------------------------------------------
   reg [PW-1:0] period_cnt_reg;
   reg [PW-1:0] expected_reg;
   reg have_expected_reg;
   reg line_start_reg;
   reg h_in_tol_reg;
   reg h_missing_reg;
   reg [5:0] last_format_reg;

   wire [PW-1:0] period_diff = (period_cnt_reg > expected_reg) ? (period_cnt_reg - expected_reg)
                                                                : (expected_reg - period_cnt_reg);
   wire [4:0] tol_shift = `TOL_EXP_BASE - {1'b0, tol_reg};
   wire [PW-1:0] allowed_drift = expected_reg >> tol_shift;
   wire [PW:0] gap_limit = {expected_reg, 1'b0};

   // Period counter restarts on each line edge; two lost lines flag the reference missing
   always @(posedge SYS_CLK)
   begin
      if (!RSTN)
      begin
         period_cnt_reg <= {PW{1'b0}};
         expected_reg <= {PW{1'b0}};
         have_expected_reg <= 1'b0;
         line_start_reg <= 1'b0;
         h_in_tol_reg <= 1'b0;
         h_missing_reg <= 1'b1;
         last_format_reg <= 6'h00;
      end
      else if (CE)
      begin
         last_format_reg <= REF_FORMAT;
         // New format id forgets expected period
         if (REF_FORMAT != last_format_reg || !FORMAT_VALID)
         begin
            have_expected_reg <= 1'b0;
            h_in_tol_reg <= 1'b0;
            line_start_reg <= 1'b0;
         end
         else if (h_edge)
         begin
            // The first edge only opens a period; a partial period must not become the reference
            if (!line_start_reg)
               line_start_reg <= 1'b1;
            else if (!have_expected_reg)
            begin
               expected_reg <= period_cnt_reg;
               have_expected_reg <= 1'b1;
            end
            else
               h_in_tol_reg <= (period_diff <= allowed_drift);
         end
         if (h_edge)
         begin
            period_cnt_reg <= {PW{1'b0}};
            h_missing_reg <= 1'b0;
         end
         else
         begin
            // Saturates so a dead input cannot wrap round into a false period
            if (period_cnt_reg != {PW{1'b1}})
               period_cnt_reg <= period_cnt_reg + 1'b1;
            if (have_expected_reg && ({1'b0, period_cnt_reg} > gap_limit))
               h_missing_reg <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Picture and field presence watchdogs
   // ----------------------------------------------------------------
   reg [31:0] v_gap_reg;
   reg [31:0] f_gap_reg;
   wire v_ok = (v_gap_reg < FRAME_GAP_CYC);
   wire f_ok = (f_gap_reg < FRAME_GAP_CYC);

   // Gap counters saturate at the limit, restart on each edge
   always @(posedge SYS_CLK)
   begin
      if (!RSTN)
      begin
         v_gap_reg <= FRAME_GAP_CYC;
         f_gap_reg <= FRAME_GAP_CYC;
      end
      else if (CE)
      begin
         if (v_edge)
            v_gap_reg <= 32'h0000_0000;
         else if (v_ok)
            v_gap_reg <= v_gap_reg + 32'h0000_0001;
         if (f_edge)
            f_gap_reg <= 32'h0000_0000;
         else if (f_ok)
            f_gap_reg <= f_gap_reg + 32'h0000_0001;
      end
   end

   // ----------------------------------------------------------------
   // Lock decision
   // ----------------------------------------------------------------
   wire ref_lost_now = !FORMAT_VALID || h_missing_reg;
   // Ignore bits widen the locked view
   wire h_good = h_in_tol_reg || ctrl_reg[`CTRL_IGN_H_BIT];
   wire v_good = v_ok || ctrl_reg[`CTRL_IGN_V_BIT];
   wire f_good = f_ok || ctrl_reg[`CTRL_IGN_F_BIT];
   wire std_enabled = (REF_FORMAT < `NUM_STANDARDS) && !mask_reg[REF_FORMAT];
   wire [3:0] crash_lines = run_reg[`CRASH_MSB:`CRASH_LSB];

   reg [4:0] line_cnt_reg;
   reg [4:0] line_cnt_next;
   reg was_locked_reg;
   reg was_locked_next;
   reg drift_reg;
   reg drift_next;

   // Next state; a new attempt starts from FREE whenever request and reference are both present
   always @*
   begin
      state_next = state_reg;
      line_cnt_next = line_cnt_reg;
      was_locked_next = was_locked_reg;
      drift_next = drift_reg;
      case (state_reg)
         ST_FREE:
         begin
            if (!ref_lost_now && lock_request_low)
               state_next = ST_CHECK;
         end
         ST_CHECK:
         begin
            if (ref_lost_now || !lock_request_low)
               state_next = ST_FREE;
            else if (TABLE_PERMIT && std_enabled)
            begin
               state_next = ST_LOCKING;
               line_cnt_next = 5'd0;
               // Crash unless drift chosen or re-acquiring
               drift_next = ctrl_reg[`CTRL_DRIFT_BIT] || was_locked_reg;
            end
         end
         ST_LOCKING:
         begin
            if (ref_lost_now || !lock_request_low)
               state_next = ST_FREE;
            else if (h_edge)
            begin
               line_cnt_next = line_cnt_reg + 5'd1;
               // Offsets applied for the lock span, then lock reported
               if ((drift_reg && line_cnt_reg == `DRIFT_LINES - 5'd1) ||
                   (!drift_reg && line_cnt_reg == {1'b0, crash_lines}))
               begin
                  state_next = ST_LOCKED;
                  was_locked_next = 1'b1;
               end
            end
         end
         ST_LOCKED:
         begin
            // Mask not looked at once locked
            if (!lock_request_low)
            begin
               state_next = ST_FREE;
               was_locked_next = 1'b0;
            end
            else if (ref_lost_now || !h_good || !v_good || !f_good)
               state_next = ST_FREE;
         end
         default:
            state_next = ST_FREE;
      endcase
      // A new standard is a new reference, not a re-acquisition
      if (REF_FORMAT != last_format_reg)
         was_locked_next = 1'b0;
   end

   // State registers and lock pins
   always @(posedge SYS_CLK)
   begin
      if (!RSTN)
      begin
         state_reg <= ST_FREE;
         line_cnt_reg <= 5'd0;
         was_locked_reg <= 1'b0;
         drift_reg <= 1'b0;
         REF_LOST <= 1'b1;
         LOCK_LOST <= 1'b1;
         DRIFT_MODE <= 1'b0;
         OFFSET_APPLY <= 1'b0;
      end
      else if (CE)
      begin
         state_reg <= state_next;
         line_cnt_reg <= line_cnt_next;
         was_locked_reg <= was_locked_next;
         drift_reg <= drift_next;
         REF_LOST <= ref_lost_now;
         // High unless locked, free run otherwise
         LOCK_LOST <= (state_next != ST_LOCKED);
         DRIFT_MODE <= drift_next;
         // Offset adjust runs before lock-lost falls
         OFFSET_APPLY <= (state_next == ST_LOCKING);
      end
   end

   // ----------------------------------------------------------------
   // Wishbone register slave
   // ----------------------------------------------------------------
   wire [7:0] idx = WB_ADR_I[9:2];
   wire req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
   wire wr = req && WB_WE_I;
   wire [2:0] lock_flags = (state_reg == ST_LOCKED) ? {f_ok, v_ok, h_in_tol_reg} : 3'b000;

   // Merge the two low byte lanes into a 16-bit register
   function [15:0] lanes;
      input [15:0] old;
      input [31:0] dat;
      input [3:0] sel;
      begin
         lanes = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
      end
   endfunction

   // Writes land on the acknowledged cycle; ack is a one-cycle pulse
   always @(posedge SYS_CLK)
   begin
      if (!RSTN)
      begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= 32'h0000_0000;
         mask_reg <= `MASK_RESET;
         ctrl_reg <= `CTRL_RESET;
         tol_reg <= `TOL_RESET;
         run_reg <= `RUN_RESET;
         vcap_reg <= `VCAP_RESET;
         vres_reg <= `VRES_RESET;
         acap_reg <= `ACAP_RESET;
         ares_reg <= `ARES_RESET;
         aud_reg <= `AUD_RESET;
      end
      else if (CE)
      begin
         WB_ACK_O <= req;
         if (wr)
         begin
            case (idx)
               `IDX_MASK_LO: mask_reg[15:0] <= lanes(mask_reg[15:0], WB_DAT_I, WB_SEL_I);
               `IDX_MASK_MID: mask_reg[31:16] <= lanes(mask_reg[31:16], WB_DAT_I, WB_SEL_I);
               `IDX_MASK_HI: mask_reg[47:32] <= lanes(mask_reg[47:32], WB_DAT_I, WB_SEL_I);
               `IDX_GEN_CTRL: ctrl_reg <= lanes(ctrl_reg, WB_DAT_I, WB_SEL_I);
               `IDX_TOLERANCE:
               begin
                  if (WB_SEL_I[0])
                     tol_reg <= WB_DAT_I[3:0];
               end
               `IDX_RUN_CTRL: run_reg <= lanes(run_reg, WB_DAT_I, WB_SEL_I);
               `IDX_VCAP: vcap_reg <= lanes(vcap_reg, WB_DAT_I, WB_SEL_I);
               `IDX_VRES: vres_reg <= lanes(vres_reg, WB_DAT_I, WB_SEL_I);
               `IDX_AUDIO_CTRL: aud_reg <= lanes(aud_reg, WB_DAT_I, WB_SEL_I);
               `IDX_ACAP: acap_reg <= lanes(acap_reg, WB_DAT_I, WB_SEL_I);
               `IDX_ARES: ares_reg <= lanes(ares_reg, WB_DAT_I, WB_SEL_I);
               default: ;
            endcase
         end
         // Unmapped reads answer zero
         case (idx)
            `IDX_MASK_LO: WB_DAT_O <= {16'h0000, mask_reg[15:0]};
            `IDX_MASK_MID: WB_DAT_O <= {16'h0000, mask_reg[31:16]};
            `IDX_MASK_HI: WB_DAT_O <= {16'h0000, mask_reg[47:32]};
            `IDX_GEN_CTRL: WB_DAT_O <= {16'h0000, ctrl_reg};
            // Separate line, picture, field lock bits
            `IDX_GEN_STAT: WB_DAT_O <= {24'h000000, drift_reg, REF_LOST, LOCK_LOST, lock_flags, state_reg};
            `IDX_TOLERANCE: WB_DAT_O <= {28'h0000000, tol_reg};
            `IDX_RUN_CTRL: WB_DAT_O <= {16'h0000, run_reg};
            `IDX_VCAP: WB_DAT_O <= {16'h0000, vcap_reg};
            `IDX_VRES: WB_DAT_O <= {16'h0000, vres_reg};
            `IDX_AUDIO_CTRL: WB_DAT_O <= {16'h0000, aud_reg};
            `IDX_ACAP: WB_DAT_O <= {16'h0000, acap_reg};
            `IDX_ARES: WB_DAT_O <= {16'h0000, ares_reg};
            default: WB_DAT_O <= 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Loop filter coefficient outputs
   // ----------------------------------------------------------------
   // Coefficients pass straight on; range limits are the host's job
   always @(posedge SYS_CLK)
   begin
      if (!RSTN)
      begin
         VIDEO_CAP <= `VCAP_RESET;
         VIDEO_RES <= `VRES_RESET;
         SOUND_CAP <= `ACAP_RESET;
         SOUND_RES <= `ARES_RESET;
         TRIPLE_RATE_SOUND_ENABLE <= 1'b0;
      end
      else if (CE)
      begin
         VIDEO_CAP <= vcap_reg;
         VIDEO_RES <= vres_reg;
         SOUND_CAP <= acap_reg;
         SOUND_RES <= ares_reg;
         TRIPLE_RATE_SOUND_ENABLE <= aud_reg[`AUD_TRIPLE_BIT];
      end
   end

endmodule // genlock_lock_control

//--- dv/genlock_lock_control_checker.sv
// Port-level concurrent checks for the genlock lock control
`include "genlock_lock_control_regs.vh"
module genlock_lock_control_checker #(
   parameter PW = 16,
   parameter FRAME_GAP_CYC = 2000
)(
   input wire logic SYS_CLK,
   input wire logic RSTN,
   input wire logic CE,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [9:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   input wire logic WB_ACK_O,
   input wire logic LOCK_REQUEST_LOW_N,
   input wire logic FORMAT_VALID,
   input wire logic REF_LOST,
   input wire logic LOCK_LOST,
   input wire logic DRIFT_MODE,
   input wire logic OFFSET_APPLY,
   input wire logic [15:0] VIDEO_CAP,
   input wire logic [15:0] SOUND_RES
);
   timeunit 1ns;
   timeprecision 1ns;
   // ------------------------------
   // Assertions
   // ------------------------------
   default clocking dc @(posedge SYS_CLK);
   endclocking
   default disable iff (!RSTN);
   ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("ack held longer than one cycle");
   ack_latency_a: assert property (CE && WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
      else $error("ack missing one cycle after request");
   ack_cause_a: assert property ($rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I))
      else $error("ack without request");
   lock_cond_a: assert property ($fell(LOCK_LOST) |-> !$past(REF_LOST) && !$past(LOCK_REQUEST_LOW_N, 4))
      else $error("lock without reference or request");
   offset_first_a: assert property ($fell(LOCK_LOST) |-> $past(OFFSET_APPLY))
      else $error("lock reached without offset phase");
   offset_unlocked_a: assert property (OFFSET_APPLY |-> LOCK_LOST)
      else $error("lock lost low while offsets apply");
   reflost_valid_a: assert property (!FORMAT_VALID |-> ##[0:2] REF_LOST)
      else $error("reference lost not raised");
   drift_slow_a: assert property ($rose(OFFSET_APPLY) && DRIFT_MODE |-> OFFSET_APPLY[*8])
      else $error("drift lock finished too soon");
   vcap_copy_a: assert property (WB_ACK_O && WB_WE_I && WB_ADR_I[9:2] == `IDX_VCAP && WB_SEL_I[1:0] == 2'b11
      |=> VIDEO_CAP == $past(WB_DAT_I[15:0])) else $error("video cap output not updated");
   sres_copy_a: assert property (WB_ACK_O && WB_WE_I && WB_ADR_I[9:2] == `IDX_ARES && WB_SEL_I[1:0] == 2'b11
      |=> SOUND_RES == $past(WB_DAT_I[15:0])) else $error("sound res output not updated");
endmodule // genlock_lock_control_checker

bind genlock_lock_control genlock_lock_control_checker #(.PW(PW), .FRAME_GAP_CYC(FRAME_GAP_CYC)) chk_inst (
   .SYS_CLK(SYS_CLK), .RSTN(RSTN), .CE(CE), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
   .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_ACK_O(WB_ACK_O),
   .LOCK_REQUEST_LOW_N(LOCK_REQUEST_LOW_N), .FORMAT_VALID(FORMAT_VALID), .REF_LOST(REF_LOST),
   .LOCK_LOST(LOCK_LOST), .DRIFT_MODE(DRIFT_MODE), .OFFSET_APPLY(OFFSET_APPLY), .VIDEO_CAP(VIDEO_CAP),
   .SOUND_RES(SOUND_RES));

//--- dv/ref_sync_source.sv
// Model of the external video reference feeding the sync pins
module ref_sync_source (
   input wire logic clk,
   input wire logic en,
   input wire logic [7:0] period,
   output logic line_out,
   output logic picture_out,
   output logic field_out,
   output logic valid_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // ------------------------------
   // Pulse generator
   // ------------------------------
   logic [7:0] cnt_reg;
   logic [3:0] line_reg;
   initial
   begin
      cnt_reg = 8'h00;
      line_reg = 4'h0;
      {line_out, picture_out, field_out, valid_out} = 4'h0;
   end
   // Pins sit low when switched off; line pulses are four clocks wide so the two-stage sync cannot miss them
   always @(posedge clk)
   begin
      if (!en)
      begin
         cnt_reg <= 8'h00;
         line_reg <= 4'h0;
         {line_out, picture_out, field_out, valid_out} <= 4'h0;
      end
      else
      begin
         cnt_reg <= (cnt_reg >= period - 8'h01) ? 8'h00 : cnt_reg + 8'h01;
         line_reg <= (cnt_reg == 8'h00) ? line_reg + 4'h1 : line_reg;
         line_out <= cnt_reg < 8'h04;
         picture_out <= cnt_reg < 8'h04 && line_reg[2:0] == 3'h0;
         field_out <= cnt_reg < 8'h04 && line_reg == 4'h0;
         valid_out <= 1'b1;
      end
   end
endmodule // ref_sync_source

//--- dv/tb_top.sv
// Self-checking bench for the genlock lock control
`include "genlock_lock_control_regs.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   // ------------------------------
   // Wiring
   // ------------------------------
   logic SYS_CLK, RSTN, WB_CYC_I, WB_STB_I, WB_WE_I, LOCK_REQUEST_LOW_N, TABLE_PERMIT, ref_en;
   logic [9:0] WB_ADR_I;
   logic [3:0] WB_SEL_I, lane_sel;
   logic [31:0] WB_DAT_I, WB_DAT_O, rd;
   logic [5:0] REF_FORMAT;
   logic [7:0] period;
   logic WB_ACK_O, LINE_REFERENCE_IN, PICTURE_REFERENCE_IN, FIELD_REFERENCE_IN, FORMAT_VALID;
   logic REF_LOST, LOCK_LOST, DRIFT_MODE, OFFSET_APPLY, TRIPLE_RATE_SOUND_ENABLE;
   logic [15:0] VIDEO_CAP, VIDEO_RES, SOUND_CAP, SOUND_RES;
   int mismatches, total_checks, n;
   // Short frame gap keeps the picture and field watchdogs inside a reasonable run
   genlock_lock_control #(.FRAME_GAP_CYC(2000)) genlock_lock_control_inst (
      .SYS_CLK(SYS_CLK), .RSTN(RSTN), .CE(1'b1), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
      .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
      .LINE_REFERENCE_IN(LINE_REFERENCE_IN), .PICTURE_REFERENCE_IN(PICTURE_REFERENCE_IN),
      .FIELD_REFERENCE_IN(FIELD_REFERENCE_IN), .LOCK_REQUEST_LOW_N(LOCK_REQUEST_LOW_N),
      .FORMAT_VALID(FORMAT_VALID), .REF_FORMAT(REF_FORMAT), .TABLE_PERMIT(TABLE_PERMIT), .REF_LOST(REF_LOST),
      .LOCK_LOST(LOCK_LOST), .DRIFT_MODE(DRIFT_MODE), .OFFSET_APPLY(OFFSET_APPLY), .VIDEO_CAP(VIDEO_CAP),
      .VIDEO_RES(VIDEO_RES), .SOUND_CAP(SOUND_CAP), .SOUND_RES(SOUND_RES),
      .TRIPLE_RATE_SOUND_ENABLE(TRIPLE_RATE_SOUND_ENABLE));
   ref_sync_source ref_sync_source_inst (.clk(SYS_CLK), .en(ref_en), .period(period), .line_out(LINE_REFERENCE_IN),
      .picture_out(PICTURE_REFERENCE_IN), .field_out(FIELD_REFERENCE_IN), .valid_out(FORMAT_VALID));
   // ------------------------------
   // Helpers
   // ------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic give_up;
      mismatches++;
      summarize();
   endtask
   // One classic cycle; request held until ack is sampled, read data taken at that edge
   task automatic wb(input logic we, input logic [7:0] idx, input logic [31:0] wd);
      int k;
      k = 0;
      @(posedge SYS_CLK);
      WB_CYC_I <= 1'b1;
      WB_STB_I <= 1'b1;
      WB_WE_I <= we;
      WB_SEL_I <= lane_sel;
      WB_ADR_I <= {idx, 2'b00};
      WB_DAT_I <= wd;
      do
      begin
         @(posedge SYS_CLK);
         k++;
      end
      while (WB_ACK_O !== 1'b1 && k < 50);
      rd = WB_DAT_O;
      WB_CYC_I <= 1'b0;
      WB_STB_I <= 1'b0;
      if (k >= 50)
         give_up();
   endtask
   task automatic wait_lock(input int lim, input logic exp);
      n = 0;
      while (LOCK_LOST !== 1'b0 && n < lim)
      begin
         @(posedge SYS_CLK);
         n++;
      end
      if (exp && n >= lim)
         give_up();
   endtask
   task automatic try_lock(input logic [5:0] fmt, input logic permit, input logic exp);
      REF_FORMAT <= fmt;
      TABLE_PERMIT <= permit;
      ref_en <= 1'b1;
      repeat (300) @(posedge SYS_CLK);
      LOCK_REQUEST_LOW_N <= 1'b0;
      wait_lock(1500, exp);
      check(32'(LOCK_LOST), 32'(!exp));
   endtask
   task automatic release_ref;
      LOCK_REQUEST_LOW_N <= 1'b1;
      ref_en <= 1'b0;
      repeat (100) @(posedge SYS_CLK);
   endtask
   // ------------------------------
   // Scenarios
   // ------------------------------
   task automatic sc_reset;
      logic [7:0] idx [10] = '{8'h1e, 8'h11, 8'h12, 8'h13, 8'h31, 8'h26, 8'h27, 8'h39, 8'h3a, 8'h05};
      logic [15:0] val [10] = '{16'h000b, 16'hf000, 16'h0003, 16'h0000, 16'h0000, 16'h0010, 16'h0025,
         16'h0010, 16'h0025, 16'h0000};
      check(32'(REF_LOST & LOCK_LOST), 32'h1);
      for (int i = 0; i < 10; i++)
      begin
         wb(1'b0, idx[i], 32'h0);
         check(rd & 32'hffff, 32'(val[i]));
      end
   endtask
   task automatic sc_regs;
      for (int k = 0; k < 16; k++)
      begin
         wb(1'b1, `IDX_TOLERANCE, 32'(k));
         wb(1'b0, `IDX_TOLERANCE, 32'h0);
         check(rd & 32'hf, 32'(k));
      end
      wb(1'b1, `IDX_VRES, 32'h0022);
      wb(1'b1, `IDX_VCAP, 32'h000d);
      wb(1'b1, `IDX_ARES, 32'h0028);
      wb(1'b1, `IDX_ACAP, 32'h0013);
      wb(1'b1, `IDX_AUDIO_CTRL, 32'h0020);
      wb(1'b1, 8'h05, 32'hffff);
      check({VIDEO_CAP, VIDEO_RES}, 32'h000d_0022);
      check({SOUND_CAP, SOUND_RES}, 32'h0013_0028);
      check(32'(TRIPLE_RATE_SOUND_ENABLE), 32'h1);
      // Low lane write keeps the high byte
      lane_sel = 4'h1;
      wb(1'b1, `IDX_VRES, 32'hff26);
      lane_sel = 4'hf;
      wb(1'b0, `IDX_VRES, 32'h0);
      check(rd, 32'h0000_0026);
   endtask
   task automatic sc_refused;
      try_lock(6'd12, 1'b1, 1'b0);
      release_ref();
      try_lock(6'd3, 1'b0, 1'b0);
      release_ref();
      ref_en <= 1'b1;
      TABLE_PERMIT <= 1'b1;
      repeat (1500) @(posedge SYS_CLK);
      check(32'(LOCK_LOST), 32'h1);
      release_ref();
   endtask
   task automatic sc_crash;
      try_lock(6'd3, 1'b1, 1'b1);
      check(32'(n < 400 && DRIFT_MODE === 1'b0), 32'h1);
      wb(1'b0, `IDX_GEN_STAT, 32'h0);
      check(rd & 32'h3c, 32'h1c);
      // Mask written while locked must not break lock
      wb(1'b1, `IDX_MASK_LO, 32'hffff);
      repeat (600) @(posedge SYS_CLK);
      check(32'(LOCK_LOST), 32'h0);
      wb(1'b1, `IDX_MASK_LO, 32'hf000);
      ref_en <= 1'b0;
      repeat (400) @(posedge SYS_CLK);
      check(32'(REF_LOST & LOCK_LOST), 32'h1);
      ref_en <= 1'b1;
      wait_lock(2000, 1'b1);
      check(32'(DRIFT_MODE), 32'h1);
      release_ref();
   endtask
   task automatic sc_drift;
      wb(1'b1, `IDX_GEN_CTRL, 32'h0002);
      try_lock(6'd3, 1'b1, 1'b1);
      check(32'(n >= 960 && DRIFT_MODE === 1'b1), 32'h1);
      // One cycle of drift on a 64 cycle line: inside code Fh, outside code 0h
      period <= 8'd65;
      repeat (800) @(posedge SYS_CLK);
      check(32'(LOCK_LOST), 32'h0);
      wb(1'b1, `IDX_TOLERANCE, 32'h0);
      repeat (300) @(posedge SYS_CLK);
      check(32'(LOCK_LOST), 32'h1);
      // Ignoring line timing lets the drifting reference hold lock
      wb(1'b1, `IDX_GEN_CTRL, 32'h0006);
      wait_lock(1500, 1'b1);
      repeat (300) @(posedge SYS_CLK);
      check(32'(LOCK_LOST), 32'h0);
      period <= 8'd64;
      wb(1'b1, `IDX_GEN_CTRL, 32'h0);
      release_ref();
   endtask
   // ------------------------------
   // Clock, reset and sequence
   // ------------------------------
   initial
   begin
      SYS_CLK = 1'b0;
      forever #25 SYS_CLK = ~SYS_CLK;
   end
   initial
   begin
      {RSTN, WB_CYC_I, WB_STB_I, WB_WE_I, TABLE_PERMIT, ref_en} = 6'h00;
      LOCK_REQUEST_LOW_N = 1'b1;
      WB_ADR_I = 10'h000;
      WB_DAT_I = 32'h0;
      WB_SEL_I = 4'hf;
      lane_sel = 4'hf;
      REF_FORMAT = 6'h00;
      period = 8'd64;
      mismatches = 0;
      total_checks = 0;
      repeat (12) @(posedge SYS_CLK);
      RSTN <= 1'b1;
      sc_reset();
      sc_regs();
      sc_refused();
      sc_crash();
      sc_drift();
      summarize();
   end
endmodule // tb_top
